// File: alrs_defines.vh
`ifndef ALRS_DEFINES_VH
`define ALRS_DEFINES_VH

// Register indices; byte address is four times the index
`define ALRS_IDX_RD_LO 14'h1805
`define ALRS_IDX_RD_HI 14'h1806
`define ALRS_IDX_CMD 14'h1807
`define ALRS_IDX_STS 14'h1808
`define ALRS_IDX_INGR 14'h1810
`define ALRS_IDX_IRQ_STS 14'h1811
`define ALRS_IDX_IRQ_EN 14'h1812
`define ALRS_IDX_IRQ_CLR 14'h1813

// Command register bits
`define ALRS_CMD_FIRST 0
`define ALRS_CMD_NEXT 1
`define ALRS_CMD_MAKE 2

// High readback word fields
`define ALRS_HI_VALID 24
`define ALRS_HI_END 23
`define ALRS_HI_STATIC 22
`define ALRS_HI_FILTER 21
`define ALRS_HI_PRIO_MSB 20
`define ALRS_HI_PRIO_LSB 19
`define ALRS_HI_PORT_MSB 18
`define ALRS_HI_PORT_LSB 16
`define ALRS_HI_MAC_MSB 15

// Status word fields
`define ALRS_STS_MAKE 0
`define ALRS_STS_INIT 1

// Ingress configuration field
`define ALRS_INGR_DPF 5
`define ALRS_INGR_RST 32'h00000000

// Interrupt event bits
`define ALRS_EV_INIT 0
`define ALRS_EV_SCAN 1
`define ALRS_EV_MAKE 2
`define ALRS_EV_W 3

// Stored entry: valid, static, filter, prio[1:0], port[2:0], mac[47:0]
`define ALRS_ENT_W 56
`define ALRS_E_VALID 55
`define ALRS_E_STATIC 54
`define ALRS_E_FILTER 53
`define ALRS_E_PRIO_MSB 52
`define ALRS_E_PRIO_LSB 51
`define ALRS_E_PORT_MSB 50
`define ALRS_E_PORT_LSB 48

// Timing
`define ALRS_CLK_PERIOD_NS 20
`define ALRS_INIT_TIME_NS 20000
`define ALRS_INIT_CYCLES ((`ALRS_INIT_TIME_NS) / (`ALRS_CLK_PERIOD_NS))
`define ALRS_CNT_W 11

`endif

// File: alrs_table_status.v
// How it works
// - Scan command write clears entry-found flag
// - Found flag set on valid entry only
// - Table-end flag set when scan reaches end
// - Readback meaningful only with found or end
// - Scan loads 64-bit entry, both words in the same cycle
// - Bit 22 reports entry exempt from aging
// - Bit 21 entry discards matching destination frames
// - Priority used only if static and dpf
// - Port field encodes host, port1, port2 sets
// - High word 15:0 holds last sixteen bits
// - Reset initializes table then sets done
// - Frames dropped while initialization runs
// - Init-done reads 0, hardware sets, read-only
// - Make-pending set during make, self clears
// - Low word holds first 32 address bits
`timescale 1ns/10ps
`include "alrs_defines.vh"
module alrs_table_status #(
   parameter DEPTH = 16,
   parameter IDXW = 4
)(
   input wire pclk, // Switch clock
   input wire presetn, // Switch fabric reset, active low
   input wire [15:0] paddr, // APB byte address
   input wire psel, // APB select
   input wire penable, // APB access phase
   input wire pwrite, // APB write
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata_ff, // APB read data
   output reg pready_ff, // APB ready
   output reg pslverr_ff, // APB error on unmapped address
   input wire [31:0] make_lo, // Entry to make, low word layout
   input wire [31:0] make_hi, // Entry to make, high word layout
   input wire lkp_req, // Frame lookup request
   input wire [47:0] lkp_mac, // Destination address to look up
   output reg lkp_done_ff, // Lookup answer strobe
   output reg lkp_hit_ff, // Address found
   output reg lkp_drop_ff, // Frame must be discarded
   output reg [1:0] lkp_prio_ff, // Entry priority
   output reg lkp_prio_use_ff, // Priority applies
   output reg [2:0] lkp_ports_ff, // Port mask: bit0 host, bit1 port1, bit2 port2
   output reg irq_ff // Level interrupt
);

localparam ST_IDLE = 2'b00;
localparam ST_INIT = 2'b01;
localparam ST_SCAN = 2'b10;
localparam ST_MAKE = 2'b11;
// Integer forms first, then cut to the counter widths on purpose
localparam integer DEPTH_I = DEPTH;
localparam integer LAST_I = DEPTH - 1;
localparam integer INIT_LAST_I = `ALRS_INIT_CYCLES - 1;
localparam [31:0] INGR_RST = `ALRS_INGR_RST;
localparam [IDXW-1:0] LAST = LAST_I[IDXW-1:0];
localparam [IDXW:0] DEPTH_X = DEPTH_I[IDXW:0];
localparam [`ALRS_CNT_W-1:0] INIT_LAST = INIT_LAST_I[`ALRS_CNT_W-1:0];

reg [`ALRS_ENT_W-1:0] tbl [0:DEPTH-1];
reg [1:0] state_ff;
reg [IDXW-1:0] ptr_ff;
reg [IDXW:0] scan_next_ff;
reg [`ALRS_CNT_W-1:0] cnt_ff;
reg wipe_done_ff;
reg init_done_ff;
reg found_ff;
reg end_ff;
reg [31:0] rb_lo_ff;
reg [22:0] rb_hi_ff;
reg [`ALRS_ENT_W-1:0] mk_ent_ff;
reg dpf_ff;
reg [`ALRS_EV_W-1:0] ist_ff;
reg [`ALRS_EV_W-1:0] ien_ff;
reg [31:0] rd_data;
reg rd_ok;
reg tbl_we;
reg [`ALRS_ENT_W-1:0] tbl_wd;
reg [`ALRS_EV_W-1:0] evt;
reg [`ALRS_EV_W-1:0] ist_clr;
reg [`ALRS_EV_W-1:0] nxt_ist;
reg [IDXW-1:0] hit_idx;
reg hit_any;
wire [`ALRS_ENT_W-1:0] cur_ent;
wire [`ALRS_ENT_W-1:0] hit_ent;
wire [DEPTH-1:0] hit_vec;
wire wr_acc;
wire [31:0] sts_word;
wire [31:0] hi_word;
integer k;

function sel;
   input [15:0] a;
   input [13:0] idx;
   begin
      sel = (a[15:2] == idx) && (a[1:0] == 2'b00);
   end
endfunction

// Multi-port codes set bit 2; 011 has no meaning and maps to no port
function [2:0] port_mask;
   input [2:0] code;
   begin
      case (code)
         3'h0: port_mask = 3'h1;
         3'h1: port_mask = 3'h2;
         3'h2: port_mask = 3'h4;
         3'h4: port_mask = 3'h3;
         3'h5: port_mask = 3'h5;
         3'h6: port_mask = 3'h6;
         3'h7: port_mask = 3'h7;
         default: port_mask = 3'h0;
      endcase
   end
endfunction

assign cur_ent = tbl[ptr_ff];
assign hit_ent = tbl[hit_idx];
assign wr_acc = psel && penable && pready_ff && pwrite;

genvar g;
generate
   for (g = 0; g < DEPTH; g = g + 1)
   begin : g_match
      assign hit_vec[g] = tbl[g][`ALRS_E_VALID] && (tbl[g][47:0] == lkp_mac);
   end
endgenerate

always @*
begin
   hit_idx = {IDXW{1'b0}};
   hit_any = 1'b0;
   for (k = DEPTH - 1; k >= 0; k = k - 1)
   begin
      if (hit_vec[k])
      begin
         hit_idx = k[IDXW-1:0];
         hit_any = 1'b1;
      end
   end
end

assign sts_word = {30'h0, init_done_ff, state_ff == ST_MAKE};
assign hi_word = {7'h00, found_ff, end_ff, rb_hi_ff};

always @*
begin
   rd_ok = 1'b1;
   rd_data = 32'h00000000;
   if (sel(paddr, `ALRS_IDX_RD_LO))
      rd_data = rb_lo_ff;
   else if (sel(paddr, `ALRS_IDX_RD_HI))
      rd_data = hi_word;
   else if (sel(paddr, `ALRS_IDX_STS))
      rd_data = sts_word;
   else if (sel(paddr, `ALRS_IDX_INGR))
      rd_data[`ALRS_INGR_DPF] = dpf_ff;
   else if (sel(paddr, `ALRS_IDX_IRQ_STS))
      rd_data[`ALRS_EV_W-1:0] = ist_ff;
   else if (sel(paddr, `ALRS_IDX_IRQ_EN))
      rd_data[`ALRS_EV_W-1:0] = ien_ff;
   else if (sel(paddr, `ALRS_IDX_CMD) || sel(paddr, `ALRS_IDX_IRQ_CLR))
      rd_data = 32'h00000000;
   else
      rd_ok = 1'b0;
end

// APB: setup cycle registers the answer, access cycle completes it
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
   end
   else if (psel && !penable)
   begin
      prdata_ff <= pwrite ? 32'h00000000 : rd_data;
      pready_ff <= 1'b1;
      pslverr_ff <= !rd_ok;
   end
   else
   begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
   end
end

// Table memory write port: wipe, make
always @*
begin
   tbl_we = 1'b0;
   tbl_wd = mk_ent_ff;
   case (state_ff)
      ST_INIT:
      begin
         tbl_we = !wipe_done_ff;
         tbl_wd = {`ALRS_ENT_W{1'b0}};
      end
      ST_MAKE:
      begin
         // Overwrite matching address, or fill a free slot with a valid entry
         tbl_we = (cur_ent[47:0] == mk_ent_ff[47:0] && cur_ent[`ALRS_E_VALID]) ||
                  (!cur_ent[`ALRS_E_VALID] && mk_ent_ff[`ALRS_E_VALID]);
      end
      default:
      begin
         tbl_we = 1'b0;
      end
   endcase
end

always @(posedge pclk)
begin
   if (tbl_we)
      tbl[ptr_ff] <= tbl_wd;
end

// Control: init, scan and make sequencing
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      state_ff <= ST_INIT;
      ptr_ff <= {IDXW{1'b0}};
      scan_next_ff <= {(IDXW+1){1'b0}};
      cnt_ff <= {`ALRS_CNT_W{1'b0}};
      wipe_done_ff <= 1'b0;
      init_done_ff <= 1'b0;
      found_ff <= 1'b0;
      end_ff <= 1'b0;
      rb_lo_ff <= 32'h00000000;
      rb_hi_ff <= 23'h000000;
      mk_ent_ff <= {`ALRS_ENT_W{1'b0}};
      dpf_ff <= INGR_RST[`ALRS_INGR_DPF];
      ien_ff <= {`ALRS_EV_W{1'b0}};
   end
   else
   begin
      if (wr_acc && sel(paddr, `ALRS_IDX_INGR))
         dpf_ff <= pwdata[`ALRS_INGR_DPF];
      if (wr_acc && sel(paddr, `ALRS_IDX_IRQ_EN))
         ien_ff <= pwdata[`ALRS_EV_W-1:0];
      if (wr_acc && sel(paddr, `ALRS_IDX_CMD) &&
          (pwdata[`ALRS_CMD_FIRST] || pwdata[`ALRS_CMD_NEXT]))
      begin
         found_ff <= 1'b0;
         end_ff <= 1'b0;
      end
      case (state_ff)
         ST_INIT:
         begin
            // Wipe runs first; the done flag waits out the full init time
            if (ptr_ff == LAST)
               wipe_done_ff <= 1'b1;
            if (!wipe_done_ff)
               ptr_ff <= ptr_ff + 1'b1;
            cnt_ff <= cnt_ff + 1'b1;
            if (cnt_ff == INIT_LAST)
            begin
               init_done_ff <= 1'b1;
               ptr_ff <= {IDXW{1'b0}};
               state_ff <= ST_IDLE;
            end
         end
         ST_IDLE:
         begin
            // Commands arriving mid-operation start nothing, though scan writes still clear found and end; one runs at a time
            if (wr_acc && sel(paddr, `ALRS_IDX_CMD))
            begin
               if (pwdata[`ALRS_CMD_FIRST])
               begin
                  ptr_ff <= {IDXW{1'b0}};
                  state_ff <= ST_SCAN;
               end
               else if (pwdata[`ALRS_CMD_NEXT])
               begin
                  if (scan_next_ff == DEPTH_X)
                     end_ff <= 1'b1;
                  else
                  begin
                     ptr_ff <= scan_next_ff[IDXW-1:0];
                     state_ff <= ST_SCAN;
                  end
               end
               else if (pwdata[`ALRS_CMD_MAKE])
               begin
                  mk_ent_ff <= {make_hi[`ALRS_HI_VALID], make_hi[`ALRS_HI_STATIC:0], make_lo};
                  ptr_ff <= {IDXW{1'b0}};
                  state_ff <= ST_MAKE;
               end
            end
         end
         ST_SCAN:
         begin
            if (cur_ent[`ALRS_E_VALID])
            begin
               found_ff <= 1'b1;
               end_ff <= (ptr_ff == LAST);
               rb_lo_ff <= cur_ent[31:0];
               rb_hi_ff <= cur_ent[`ALRS_E_STATIC:32];
               scan_next_ff <= {1'b0, ptr_ff} + 1'b1;
               state_ff <= ST_IDLE;
            end
            else if (ptr_ff == LAST)
            begin
               end_ff <= 1'b1;
               scan_next_ff <= DEPTH_X;
               state_ff <= ST_IDLE;
            end
            else
               ptr_ff <= ptr_ff + 1'b1;
         end
         ST_MAKE:
         begin
            // A full table drops the new entry silently
            if (tbl_we || ptr_ff == LAST)
               state_ff <= ST_IDLE;
            else
               ptr_ff <= ptr_ff + 1'b1;
         end
         default:
         begin
            state_ff <= ST_IDLE;
         end
      endcase
   end
end

// Interrupt events: set wins over a clear in the same cycle
always @*
begin
   evt = {`ALRS_EV_W{1'b0}};
   evt[`ALRS_EV_INIT] = (state_ff == ST_INIT) && (cnt_ff == INIT_LAST);
   evt[`ALRS_EV_SCAN] = ((state_ff == ST_SCAN) && (cur_ent[`ALRS_E_VALID] || ptr_ff == LAST)) ||
                        ((state_ff == ST_IDLE) && wr_acc && sel(paddr, `ALRS_IDX_CMD) &&
                         !pwdata[`ALRS_CMD_FIRST] && pwdata[`ALRS_CMD_NEXT] &&
                         scan_next_ff == DEPTH_X);
   evt[`ALRS_EV_MAKE] = (state_ff == ST_MAKE) && (tbl_we || ptr_ff == LAST);
   ist_clr = {`ALRS_EV_W{1'b0}};
   if (wr_acc && sel(paddr, `ALRS_IDX_IRQ_CLR))
      ist_clr = pwdata[`ALRS_EV_W-1:0];
   nxt_ist = (ist_ff & ~ist_clr) | evt;
end

always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ist_ff <= {`ALRS_EV_W{1'b0}};
      irq_ff <= 1'b0;
   end
   else
   begin
      ist_ff <= nxt_ist;
      irq_ff <= |(nxt_ist & ien_ff);
   end
end

// Frame lookup answer, one cycle after the request
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      lkp_done_ff <= 1'b0;
      lkp_hit_ff <= 1'b0;
      lkp_drop_ff <= 1'b0;
      lkp_prio_ff <= 2'b00;
      lkp_prio_use_ff <= 1'b0;
      lkp_ports_ff <= 3'h0;
   end
   else
   begin
      lkp_done_ff <= lkp_req;
      if (lkp_req)
      begin
         lkp_hit_ff <= hit_any && init_done_ff;
         lkp_drop_ff <= !init_done_ff || (hit_any && hit_ent[`ALRS_E_FILTER]);
         // Gated so a miss, or an unwiped table during init, reports priority zero
         lkp_prio_ff <= (hit_any && init_done_ff) ? hit_ent[`ALRS_E_PRIO_MSB:`ALRS_E_PRIO_LSB] : 2'b00;
         lkp_prio_use_ff <= init_done_ff && hit_any && hit_ent[`ALRS_E_STATIC] && dpf_ff;
         lkp_ports_ff <= (hit_any && init_done_ff) ?
                         port_mask(hit_ent[`ALRS_E_PORT_MSB:`ALRS_E_PORT_LSB]) : 3'h0;
      end
   end
end

endmodule

// File: alrs_chk_assertions.sv
`timescale 1ns/10ps
module alrs_chk (
   input wire pclk, // Clock
   input wire presetn, // Reset
   input wire [15:0] paddr, // Address
   input wire psel, // Select
   input wire penable, // Access
   input wire pwrite, // Write
   input wire [31:0] prdata_ff, // Data
   input wire pready_ff, // Ready
   input wire pslverr_ff, // Error
   input wire lkp_req, // Lookup
   input wire lkp_done_ff, // Answer
   input wire lkp_drop_ff // Drop
);
   reg [11:0] cnt_ff;
   wire rd = pready_ff && !pwrite;
   wire al = paddr[1:0] == 2'h0;
   wire map = al && ((paddr >= 16'h6014 && paddr <= 16'h6020) || (paddr >= 16'h6040 && paddr <= 16'h604C));
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Cycles since reset release, saturating so late reads stay covered
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_ff <= 12'h000;
      else if (cnt_ff != 12'hFFF)
         cnt_ff <= cnt_ff + 12'h001;
   end
   a_rdy_setup: assert property (psel && !penable |=> pready_ff)
      else $error("no ready after setup");
   a_rdy_once: assert property (pready_ff |=> !pready_ff)
      else $error("ready too long");
   a_err_unmap: assert property (pready_ff |-> pslverr_ff == !map)
      else $error("wrong error flag");
   a_sts_rsvd: assert property (rd && paddr == 16'h6020 |-> prdata_ff[31:2] == 30'h0)
      else $error("status reserved bits set");
   a_hi_rsvd: assert property (rd && paddr == 16'h6018 |-> prdata_ff[31:25] == 7'h00)
      else $error("high word reserved bits set");
   a_init_low: assert property (rd && paddr == 16'h6020 && cnt_ff < 12'h3DE |-> !prdata_ff[1])
      else $error("init done too early");
   a_init_high: assert property (rd && paddr == 16'h6020 && cnt_ff > 12'h3F2 |-> prdata_ff[1])
      else $error("init done too late");
   a_lkp_answer: assert property (lkp_req |=> lkp_done_ff)
      else $error("lookup not answered");
   a_lkp_cause: assert property (lkp_done_ff |-> $past(lkp_req))
      else $error("answer without request");
   a_drop_init: assert property (lkp_done_ff && cnt_ff < 12'h3DE |-> lkp_drop_ff)
      else $error("frame kept during init");
endmodule
bind alrs_table_status alrs_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata_ff,
   .pready_ff, .pslverr_ff, .lkp_req, .lkp_done_ff, .lkp_drop_ff);

// File: alrs_table_status_tb.sv
`timescale 1ns/10ps
module alrs_table_status_tb;
   reg pclk = 0;
   reg presetn = 0;
   reg [15:0] paddr = 16'h0000;
   reg psel = 0, penable = 0, pwrite = 0, lkp_req = 0, e;
   reg [31:0] pwdata = 32'h0, make_lo = 32'h0, make_hi = 32'h0, r, lo [0:5], hi [0:5];
   reg [47:0] lkp_mac = 48'h0;
   wire [31:0] prdata_ff;
   wire pready_ff, pslverr_ff, lkp_done_ff, lkp_hit_ff, lkp_drop_ff, lkp_prio_use_ff, irq_ff;
   wire [1:0] lkp_prio_ff;
   wire [2:0] lkp_ports_ff;
   integer failures = 0, checked = 0, cyc = 0, rel, i, k;
   always #10 pclk = ~pclk;
   alrs_table_status dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata_ff, .pready_ff,
      .pslverr_ff, .make_lo, .make_hi, .lkp_req, .lkp_mac, .lkp_done_ff, .lkp_hit_ff, .lkp_drop_ff,
      .lkp_prio_ff, .lkp_prio_use_ff, .lkp_ports_ff, .irq_ff);
   function [2:0] pm(input [2:0] p);
      case (p)
         3'h0: pm = 3'h1;
         3'h1: pm = 3'h2;
         3'h2: pm = 3'h4;
         3'h4: pm = 3'h3;
         default: pm = p;
      endcase
   endfunction
   // Packed as hit, drop, prio_use, prio, ports
   function [7:0] lx(input [31:0] h, input d);
      lx = {1'h1, h[21], h[22] & d, h[20:19], pm(h[18:16])};
   endfunction
   task test_done;
      begin
         $display("checked %0d failures %0d", checked, failures);
         if (failures == 0 && checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] s, input [31:0] x);
      begin
         checked = checked + 1;
         if (s !== x)
         begin
            failures = failures + 1;
            $display("FAIL %s exp %h got %h", nm, x, s);
         end
      end
   endtask
   task apb(input [15:0] a, input w, input [31:0] d);
      integer t;
      begin
         psel <= 1'h1;
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         t = 0;
         @(posedge pclk);
         while (pready_ff !== 1'h1 && t < 40)
         begin
            @(posedge pclk);
            t = t + 1;
         end
         r = prdata_ff;
         e = pslverr_ff;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge pclk);
      end
   endtask
   // Repeats a read until the masked bits reach the wanted state
   task poll(input [15:0] a, input [31:0] m, input f);
      integer t;
      begin
         t = 0;
         apb(a, 0, 0);
         while ((|(r & m)) != f && t < 30)
         begin
            apb(a, 0, 0);
            t = t + 1;
         end
      end
   endtask
   task sc(input [31:0] c);
      begin
         apb(16'h601C, 1, c);
         poll(16'h6018, 32'h01800000, 1);
      end
   endtask
   task lk(input [47:0] m, input [7:0] x);
      begin
         lkp_req <= 1'h1;
         lkp_mac <= m;
         @(posedge pclk);
         lkp_req <= 1'h0;
         @(posedge pclk);
         chk("lookup", {lkp_hit_ff, lkp_drop_ff, lkp_prio_use_ff, lkp_prio_ff, lkp_ports_ff}, x);
         chk("done", lkp_done_ff, 32'h1);
      end
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 9000)
      begin
         failures = failures + 1;
         test_done;
      end
   end
   initial
   begin
      k = $urandom(92635);
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      rel = cyc;
      @(posedge pclk);
      apb(16'h6020, 0, 0);
      chk("sts", r, 32'h0);
      lk(48'h1, 8'h40);
      while (cyc < rel + 960) @(posedge pclk);
      apb(16'h6020, 0, 0);
      chk("sts", r, 32'h0);
      while (cyc < rel + 1010) @(posedge pclk);
      apb(16'h6020, 1, 32'hFFFFFFFF);
      apb(16'h6020, 0, 0);
      chk("sts", r, 32'h2);
      chk("irq", irq_ff, 32'h0);
      apb(16'h6044, 0, 0);
      chk("irq_sts", r, 32'h1);
      apb(16'h6048, 1, 32'h1);
      @(posedge pclk);
      chk("irq", irq_ff, 32'h1);
      apb(16'h604C, 1, 32'h1);
      @(posedge pclk);
      chk("irq", irq_ff, 32'h0);
      for (i = 0; i < 6; i = i + 1)
      begin
         k = $urandom;
         lo[i] = $urandom;
         hi[i] = {7'h00, 2'h2, k[22:0]};
         if (hi[i][18:16] == 3'h3)
            hi[i][18] = 1'h1;
         make_lo <= lo[i];
         make_hi <= hi[i];
         apb(16'h601C, 1, 32'h4);
         apb(16'h6020, 0, 0);
         // Later slots take longer, so pending is sure to be seen there
         if (i > 3)
            chk("pend", r[0], 32'h1);
         poll(16'h6020, 32'h1, 0);
         chk("sts", r, 32'h2);
      end
      for (k = 0; k < 2; k = k + 1)
      begin
         apb(16'h6040, 1, k << 5);
         for (i = 0; i < 6; i = i + 1)
            lk({hi[i][15:0], lo[i]}, lx(hi[i], k[0]));
      end
      lk({16'hFFFF, ~lo[0]}, 8'h00);
      for (i = 0; i < 6; i = i + 1)
      begin
         sc(i == 0 ? 32'h1 : 32'h2);
         chk("rd_hi", r, hi[i]);
         apb(16'h6014, 0, 0);
         chk("rd_lo", r, lo[i]);
      end
      sc(32'h2);
      chk("end", r[24:23], 32'h1);
      sc(32'h1);
      make_lo <= $urandom;
      make_hi <= 32'h01000000;
      apb(16'h601C, 1, 32'h4);
      apb(16'h601C, 1, 32'h1);
      apb(16'h6018, 0, 0);
      chk("clr", r[24:23], 32'h0);
      poll(16'h6020, 32'h1, 0);
      k = r;
      apb(16'h6018, 0, 0);
      k = r;
      apb(16'h6018, 1, 32'hFFFFFFFF);
      apb(16'h6018, 0, 0);
      chk("ro_hi", r, k);
      apb(16'h6044, 0, 0);
      chk("irq_sts", r, 32'h6);
      apb(16'h6030, 0, 0);
      chk("unmap", e, 32'h1);
      test_done;
   end
endmodule
